// ---- hdl/mpa_cfg.svh ----
// Constants for the multipurpose pattern register access block
`ifndef MPA_CFG_SVH
`define MPA_CFG_SVH

// ----------------------------------------------------------------
// Command encodings on the simplified command bus
// ----------------------------------------------------------------
`define MPA_CMD_NOP      3'h0
`define MPA_CMD_MRS      3'h1
`define MPA_CMD_RD       3'h2
`define MPA_CMD_WR       3'h3
`define MPA_CMD_REF      3'h4
`define MPA_CMD_ACT      3'h5
`define MPA_CMD_PRE      3'h6

// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define MPA_MR0_SEL      2'h0
`define MPA_MR3_SEL      2'h3
`define MPA_MR3_EN_BIT   2
`define MPA_PAGE0        2'h0
`define MPA_BL_OTF       2'h1
`define MPA_A12_BIT      12
`define MPA_A2_BIT       2

// ----------------------------------------------------------------
// Timing (cycles of the 10 ns clock)
// ----------------------------------------------------------------
`define MPA_RL           4'h4
`define MPA_BURST_LEN    4'h8
`define MPA_BC4_LEN      4'h4
`define MPA_TMOD         4'h6
`define MPA_TWR_MPR      4'h4
`define MPA_TMPRR        4'h2
`define MPA_TRP          4'h3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MPA_PAT0_RST     8'h55
`define MPA_PAT1_RST     8'h33
`define MPA_PAT2_RST     8'h0F
`define MPA_PAT3_RST     8'h00

`endif

// ---- hdl/mpa_pkg.sv ----
// Types shared by both ends of the pattern register link
package mpa_pkg;
    // ----------------------------------------------------------------
    // Controller sequencing states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        MPA_C_IDLE,
        MPA_C_PRE,
        MPA_C_TRP,
        MPA_C_ENTER,
        MPA_C_TMOD,
        MPA_C_ACCESS,
        MPA_C_WAIT,
        MPA_C_EXIT,
        MPA_C_EXMOD
    } mpa_cstate_t;
endpackage

// ---- hdl/mpa_if.sv ----
// Command, address and data link between controller and device
`timescale 1ns/100ps
interface mpa_if;
    logic [2:0]  cmd;      // Command code, one cycle per command
    logic [1:0]  ba;       // Bank address, selects pattern location
    logic [1:0]  bg;       // Bank group, ignored in pattern mode
    logic [1:0]  mr_sel;   // Mode register selected by MRS
    logic [13:0] addr;     // Address bus
    logic [7:0]  dq_o;     // Read data from device
    logic        dq_oe;    // Device drives data
    logic        alert;    // Unused by this block, always low

    modport dev  (input cmd, ba, bg, mr_sel, addr, output dq_o, dq_oe, alert);
    modport ctrl (output cmd, ba, bg, mr_sel, addr, input dq_o, dq_oe, alert);
endinterface

// ---- hdl/mpa_pat_store.sv ----
// Four-location pattern store with staggered lane selection
`timescale 1ns/100ps
module mpa_pat_store
    import mpa_pkg::*;
(
    input  wire logic       clk_i,     // Clock
    input  wire logic       rst_n_i,   // Async reset, active low
    input  wire logic       we_i,      // Write strobe
    input  wire logic [1:0] wloc_i,    // Write location
    input  wire logic [7:0] wdata_i,   // Write data, bit n is UI n
    input  wire logic [1:0] rloc_i,    // Read start location
    output logic [31:0]     rdata_o    // Lane k holds location rloc+k
);
`include "mpa_cfg.svh"
    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [3:0][7:0] pat;          // Pattern locations
    } mpa_st_t;
    mpa_st_t st_r;                     // Registered state
    mpa_st_t st_nxt;                   // Next state

    // Only a write changes a location; exits leave data alone
    always_comb begin
        st_nxt = st_r;
        if (we_i) begin
            st_nxt.pat[wloc_i] = wdata_i;
        end
    end

    // Register the store
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r.pat[0] <= `MPA_PAT0_RST;
            st_r.pat[1] <= `MPA_PAT1_RST;
            st_r.pat[2] <= `MPA_PAT2_RST;
            st_r.pat[3] <= `MPA_PAT3_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Staggered lanes wrap modulo four
    genvar k;
    generate
        for (k = 0; k < 4; k++) begin : g_lane
            logic [1:0] loc;
            assign loc = rloc_i + 2'(k);
            assign rdata_o[k*8 +: 8] = st_r.pat[loc];
        end
    endgenerate
endmodule

// ---- hdl/mpa_dev.sv ----
// Device end: mode tracking, command redirect, pattern read path
`timescale 1ns/100ps
module mpa_dev
    import mpa_pkg::*;
(
    input  wire logic  clk_i,          // Clock
    input  wire logic  rst_n_i,        // Async reset, active low
    mpa_if.dev         bus,            // Link to controller
    input  wire logic  stagger_i,      // Staggered readout select
    input  wire logic [3:0] pl_i,      // Parity latency in cycles, 0 off
    output logic       mpr_en_o,       // Pattern mode enabled
    output logic       arr_rd_o,       // Read went to array
    output logic       arr_wr_o,       // Write went to array
    output logic       arr_act_o       // Activate accepted
);
`include "mpa_cfg.svh"
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       en;                // Pattern mode bit
        logic [1:0] page;              // Selected page
        logic [1:0] bl;                // Burst length field
        logic [4:0] dly;               // Read delay countdown
        logic [3:0] beat;              // Beats left in burst
        logic [3:0] blen;              // Beats with real data
        logic [1:0] loc;               // Location being read
        logic       stg;               // Stagger latched
        logic [2:0] ui;                // Current unit interval
        logic [7:0] dq;                // Data out
        logic       oe;                // Output enable
        logic       ard;               // Array read pulse
        logic       awr;               // Array write pulse
        logic       act;               // Activate pulse
    } mpa_dst_t;
    mpa_dst_t d_r;                     // Registered state
    mpa_dst_t d_nxt;                   // Next state

    logic [31:0] lanes;                // Staggered pattern lanes
    logic        pw;                   // Pattern write accepted
    logic        pr;                   // Pattern read accepted

    // Only mode, page and the bank bits steer the access
    assign pr = d_r.en && bus.cmd == `MPA_CMD_RD;
    assign pw = d_r.en && d_r.page == `MPA_PAGE0
                && bus.cmd == `MPA_CMD_WR;

    mpa_pat_store u_store (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .we_i    (pw),
        .wloc_i  (bus.ba),
        .wdata_i (bus.addr[7:0]),
        .rloc_i  (d_r.loc),
        .rdata_o (lanes)
    );

    // Next state: mode register decode, redirect, burst output
    always_comb begin
        d_nxt     = d_r;
        d_nxt.ard = 1'b0;
        d_nxt.awr = 1'b0;
        d_nxt.act = 1'b0;
        // Mode register writes
        if (bus.cmd == `MPA_CMD_MRS && bus.mr_sel == `MPA_MR3_SEL) begin
            d_nxt.en   = bus.addr[`MPA_MR3_EN_BIT];
            d_nxt.page = bus.addr[1:0];
        end else if (bus.cmd == `MPA_CMD_MRS && bus.mr_sel == `MPA_MR0_SEL) begin
            d_nxt.bl = bus.addr[1:0];
        end
        // Array commands when not redirected
        if (!d_r.en && bus.cmd == `MPA_CMD_RD) begin
            d_nxt.ard = 1'b1;
        end
        if (!pw && bus.cmd == `MPA_CMD_WR) begin
            d_nxt.awr = 1'b1;
        end
        if (!d_r.en && bus.cmd == `MPA_CMD_ACT) begin
            d_nxt.act = 1'b1;
        end
        // Launch a read; parity latency extends the delay
        if (pr) begin
            d_nxt.dly = 5'(`MPA_RL) + 5'(pl_i);
            d_nxt.loc = bus.ba;
            d_nxt.stg = stagger_i;
            // Chop to four only when on-the-fly and A12 low
            d_nxt.blen = (d_r.bl == `MPA_BL_OTF && !bus.addr[`MPA_A12_BIT])
                         ? `MPA_BC4_LEN : `MPA_BURST_LEN;
        end else if (d_r.dly != 5'h0) begin
            d_nxt.dly = d_r.dly - 5'h1;
            if (d_r.dly == 5'h1) begin
                d_nxt.beat = `MPA_BURST_LEN;
                d_nxt.ui   = 3'h0;
            end
        end
        // Drive beats in fixed order 0..7
        d_nxt.oe = 1'b0;
        d_nxt.dq = 8'h00;
        if (d_r.beat != 4'h0) begin
            d_nxt.oe   = 1'b1;
            d_nxt.beat = d_r.beat - 4'h1;
            d_nxt.ui   = d_r.ui + 3'h1;
            // Chopped slots carry don't-care, driven as zero
            if (4'(d_r.ui) < d_r.blen) begin
                for (int k = 0; k < 4; k++) begin
                    d_nxt.dq[k]   = d_r.stg ? lanes[k*8 + 32'(d_r.ui)]
                                            : lanes[32'(d_r.ui)];
                    d_nxt.dq[k+4] = d_nxt.dq[k];
                end
            end
        end
    end

    // Register the state
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            d_r <= '0;
        end else begin
            d_r <= d_nxt;
        end
    end

    assign bus.dq_o  = d_r.dq;
    assign bus.dq_oe = d_r.oe;
    assign bus.alert = 1'b0;
    assign mpr_en_o  = d_r.en;
    assign arr_rd_o  = d_r.ard;
    assign arr_wr_o  = d_r.awr;
    assign arr_act_o = d_r.act;
endmodule

// ---- hdl/mpa_ctrl.sv ----
// Controller end: pattern write/read sequencing through user registers
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
// Behaviour
// - Read column low bits driven zero
// - Read A2 zero, fixed burst order
// - Bank bits select pattern location
// - Drive A12 high when burst field 01
// - Device ignores unused address bits
// - Parity latency adds to read delay
// - Write stores address byte to location
// - Address bit n becomes UI n
// - No data inversion on pattern writes
// - Written patterns persist across mode exit
// - Precharge all, wait tRP first
// - Enter with MR3 bit2 set, page 0
// - Mode on redirects reads, and writes on page 0 only
// - Wait write recovery after each write
// - Wait recovery before exit command
// - Exit by clearing MR3 bit2
// - Array commands after tMOD following exit
// - Only 1x refresh while in mode
// - Bit clear means normal array access
// - Staggered lanes rotate locations modulo four
module mpa_ctrl
    import mpa_pkg::*;
(
    input  wire logic        clk_i,     // Clock
    input  wire logic        rst_n_i,   // Async reset, active low
    mpa_if.ctrl              bus,       // Link to device
    input  wire logic [1:0]  addr_i,    // Register address
    input  wire logic [15:0] wdata_i,   // Register write data
    input  wire logic        wr_i,      // Write strobe
    input  wire logic        rd_i,      // Read strobe
    output logic [15:0]      rdata_o,   // Read data, one cycle later
    output logic             busy_o     // Sequence in progress
);
`include "mpa_cfg.svh"
    // ----------------------------------------------------------------
    // Register map: 0 command, 1 status, 2 last read byte
    // Command word: [15] go, [14] write, [13] refresh, [12] exit,
    // [11:10] location, [9:2] data
    // ----------------------------------------------------------------
    typedef struct packed {
        mpa_cstate_t st;               // Sequence state
        logic        in_mode;          // Device in pattern mode
        logic        op_wr;            // Pending op is write
        logic        op_ref;           // Pending op is refresh
        logic        op_exit;          // Pending op leaves mode
        logic [1:0]  loc;              // Location
        logic [7:0]  data;             // Write byte
        logic [3:0]  cnt;              // Wait counter
        logic [2:0]  beat;             // Captured beat index
        logic [7:0]  rbyte;            // Lane 0 byte assembled
        logic [2:0]  cmd;
        logic [1:0]  ba;
        logic [1:0]  mrs;
        logic [13:0] addr;
        logic [15:0] rdata;
        logic        busy;
    } mpa_cst_t;
    mpa_cst_t c_r;                     // Registered state
    mpa_cst_t c_nxt;                   // Next state

    // Sequencer and register port
    always_comb begin
        c_nxt      = c_r;
        c_nxt.cmd  = `MPA_CMD_NOP;
        c_nxt.addr = 14'h0000;
        c_nxt.ba   = 2'h0;
        c_nxt.mrs  = 2'h0;
        // Register reads answer in the next cycle
        c_nxt.rdata = 16'h0000;
        if (rd_i) begin
            case (addr_i)
                2'h1:    c_nxt.rdata = {14'h0000, c_r.in_mode, c_r.busy};
                2'h2:    c_nxt.rdata = {8'h00, c_r.rbyte};
                default: c_nxt.rdata = 16'h0000;
            endcase
        end
        // Capture lane 0 of returning bursts, UI order
        if (bus.dq_oe) begin
            c_nxt.rbyte[c_r.beat] = bus.dq_o[0];
            c_nxt.beat = c_r.beat + 3'h1;
        end
        case (c_r.st)
            MPA_C_IDLE: begin
                if (wr_i && addr_i == 2'h0 && wdata_i[15]) begin
                    c_nxt.op_wr   = wdata_i[14];
                    c_nxt.op_ref  = wdata_i[13];
                    c_nxt.op_exit = wdata_i[12];
                    c_nxt.loc     = wdata_i[11:10];
                    c_nxt.data    = wdata_i[9:2];
                    c_nxt.busy    = 1'b1;
                    c_nxt.st = c_r.in_mode ? MPA_C_ACCESS : MPA_C_PRE;
                end
            end
            MPA_C_PRE: begin
                c_nxt.cmd = `MPA_CMD_PRE;
                c_nxt.cnt = `MPA_TRP;
                c_nxt.st  = MPA_C_TRP;
            end
            MPA_C_TRP: begin
                c_nxt.cnt = c_r.cnt - 4'h1;
                if (c_r.cnt == 4'h1) c_nxt.st = MPA_C_ENTER;
            end
            MPA_C_ENTER: begin
                c_nxt.cmd  = `MPA_CMD_MRS;
                c_nxt.mrs  = `MPA_MR3_SEL;
                c_nxt.addr = 14'h0000;
                c_nxt.addr[`MPA_MR3_EN_BIT] = 1'b1;       // page 0
                c_nxt.in_mode = 1'b1;
                c_nxt.cnt = `MPA_TMOD;
                c_nxt.st  = MPA_C_TMOD;
            end
            MPA_C_TMOD: begin
                c_nxt.cnt = c_r.cnt - 4'h1;
                if (c_r.cnt == 4'h1) c_nxt.st = MPA_C_ACCESS;
            end
            MPA_C_ACCESS: begin
                c_nxt.ba = c_r.loc;
                c_nxt.beat = 3'h0;
                if (c_r.op_exit) begin
                    c_nxt.cnt = `MPA_TMPRR;
                    c_nxt.st  = MPA_C_WAIT;
                end else if (c_r.op_ref) begin
                    c_nxt.cmd = `MPA_CMD_REF;              // 1x only
                    c_nxt.cnt = `MPA_TRP;
                    c_nxt.st  = MPA_C_WAIT;
                end else if (c_r.op_wr) begin
                    c_nxt.cmd  = `MPA_CMD_WR;
                    c_nxt.addr = {6'h00, c_r.data};        // no inversion
                    c_nxt.cnt  = `MPA_TWR_MPR;
                    c_nxt.st   = MPA_C_WAIT;
                end else begin
                    c_nxt.cmd  = `MPA_CMD_RD;
                    c_nxt.addr = 14'h0000;
                    c_nxt.addr[`MPA_A12_BIT] = 1'b1;
                    c_nxt.cnt  = 4'(`MPA_RL + `MPA_BURST_LEN);
                    c_nxt.st   = MPA_C_WAIT;
                end
            end
            MPA_C_WAIT: begin
                c_nxt.cnt = c_r.cnt - 4'h1;
                if (c_r.cnt == 4'h1) begin
                    c_nxt.st   = c_r.op_exit ? MPA_C_EXIT : MPA_C_IDLE;
                    c_nxt.busy = c_r.op_exit;
                end
            end
            MPA_C_EXIT: begin
                c_nxt.cmd  = `MPA_CMD_MRS;
                c_nxt.mrs  = `MPA_MR3_SEL;
                c_nxt.addr = 14'h0000;
                c_nxt.in_mode = 1'b0;
                c_nxt.cnt = `MPA_TMOD;
                c_nxt.st  = MPA_C_EXMOD;
            end
            MPA_C_EXMOD: begin
                c_nxt.cnt = c_r.cnt - 4'h1;
                if (c_r.cnt == 4'h1) begin
                    c_nxt.st   = MPA_C_IDLE;
                    c_nxt.busy = 1'b0;
                end
            end
            default: c_nxt.st = MPA_C_IDLE;
        endcase
    end

    // Register the state
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            c_r    <= '0;
            c_r.st <= MPA_C_IDLE;
        end else begin
            c_r <= c_nxt;
        end
    end

    assign bus.cmd    = c_r.cmd;
    assign bus.ba     = c_r.ba;
    assign bus.bg     = 2'h0;
    assign bus.mr_sel = c_r.mrs;
    assign bus.addr   = c_r.addr;
    assign rdata_o    = c_r.rdata;
    assign busy_o     = c_r.busy;
endmodule

// ---- tb/mpa_assertions.sv ----
// Concurrent checks on the controller-to-device link
`timescale 1ns/100ps
`include "mpa_cfg.svh"
module mpa_assertions (
    input wire logic        clk_i,   // Clock
    input wire logic        rst_n_i, // Async reset, active low
    input wire logic [2:0]  cmd,     // Command code
    input wire logic [1:0]  ba,      // Location select
    input wire logic [1:0]  bg,      // Bank group
    input wire logic [1:0]  mr_sel,  // Mode register number
    input wire logic [13:0] addr,    // Address bus
    input wire logic [7:0]  dq_o,    // Device read data
    input wire logic        dq_oe,   // Device drives data
    input wire logic        alert,   // Unused alert line
    input wire logic [3:0]  pl_i     // Parity latency
);
    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    logic [7:0] rd_age_r;   // Cycles since the last read command
    logic [7:0] idle_run_r; // Consecutive idle command slots

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // Both counters saturate so a long idle spell cannot wrap to a small value
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_age_r   <= 8'h00;
            idle_run_r <= 8'h00;
        end else begin
            if (cmd == `MPA_CMD_RD) begin
                rd_age_r <= 8'h01;
            end else if (rd_age_r != 8'h00 && rd_age_r != 8'hFF) begin
                rd_age_r <= rd_age_r + 8'h01;
            end
            if (cmd != `MPA_CMD_NOP) begin
                idle_run_r <= 8'h00;
            end else if (idle_run_r != 8'hFF) begin
                idle_run_r <= idle_run_r + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    sequence s_trp_gap;  (cmd == `MPA_CMD_NOP) [*3]; endsequence
    sequence s_wr_gap;   (cmd == `MPA_CMD_NOP) [*4]; endsequence
    sequence s_tmod_gap; (cmd == `MPA_CMD_NOP) [*6]; endsequence
    sequence s_burst;    dq_oe [*8] ##1 !dq_oe; endsequence
    sequence s_enter;
        cmd == `MPA_CMD_MRS && mr_sel == `MPA_MR3_SEL && addr[`MPA_MR3_EN_BIT];
    endsequence
    sequence s_exit;
        cmd == `MPA_CMD_MRS && mr_sel == `MPA_MR3_SEL && !addr[`MPA_MR3_EN_BIT];
    endsequence

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    chk_rd_col_low: assert property (
        cmd == `MPA_CMD_RD |-> addr[1:0] == 2'h0) else $error("read column bits not zero");
    chk_rd_a2_zero: assert property (
        cmd == `MPA_CMD_RD |-> !addr[`MPA_A2_BIT]) else $error("read A2 not zero");
    chk_burst_len: assert property (
        $rose(dq_oe) |-> s_burst) else $error("read burst not eight beats");
    chk_rd_latency: assert property (
        $rose(dq_oe) |-> rd_age_r == 8'(`MPA_RL) + 8'(pl_i) + 8'h02)
        else $error("read data delay wrong");
    chk_enter_page0: assert property (
        s_enter |-> addr[1:0] == `MPA_PAGE0) else $error("mode entry not on page 0");
    chk_enter_after_trp: assert property (
        s_enter |-> idle_run_r >= 8'h03) else $error("mode entry before precharge time");
    chk_pre_gap: assert property (
        cmd == `MPA_CMD_PRE |=> s_trp_gap) else $error("command inside precharge time");
    chk_mrs_tmod: assert property (
        cmd == `MPA_CMD_MRS |=> s_tmod_gap) else $error("command inside mode set delay");
    chk_wr_recovery: assert property (
        cmd == `MPA_CMD_WR |=> s_wr_gap) else $error("command inside write recovery");
    chk_exit_recover: assert property (
        s_exit |-> idle_run_r >= 8'h02) else $error("mode exit before recovery time");
endmodule

// ---- tb/tb_ddr4_mpr_access.sv ----
// Self-checking bench joining controller and device ends
`timescale 1ns/100ps
`include "mpa_cfg.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected %s expected %h seen %h", n, e, g); end end
module tb_ddr4_mpr_access;
    // ------------------------------------------------------------
    // Stimulus and bookkeeping
    // ------------------------------------------------------------
    typedef struct packed {logic [1:0] loc; logic [7:0] data; logic stg;} mpa_row_t;
    logic        clk_i   = 1'b0;  // 100 MHz clock
    logic        rst_n_i = 1'b0;  // Reset, active low
    logic [1:0]  addr    = 2'h0;  // Register address
    logic [15:0] wdata   = 16'h0; // Register write data
    logic        wr_s    = 1'b0;  // Register write strobe
    logic        rd_s    = 1'b0;  // Register read strobe
    logic        stagger = 1'b0;  // Lane rotation select
    logic [3:0]  pl      = 4'h0;  // Parity latency
    logic [15:0] rdata;           // Register read data
    logic        busy, mpr_en, arr_rd, arr_wr, arr_act;
    logic [7:0]  pat [4];         // Expected pattern store
    logic [7:0]  beats [$];       // Captured burst beats
    logic [15:0] d;
    logic        oe_q = 1'b0;
    int          cyc, rd_cyc, oe_cyc, arr_hits, bad_count, checked;
    mpa_row_t    rows [4] = '{'{2'h0, 8'hA5, 1'b0}, '{2'h1, 8'hFF, 1'b1},
                              '{2'h2, 8'h00, 1'b1}, '{2'h3, 8'h3C, 1'b0}};

    mpa_if link ();
    mpa_ctrl mpa_ctrl_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(link), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata), .busy_o(busy));
    mpa_dev mpa_dev_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(link), .stagger_i(stagger),
        .pl_i(pl), .mpr_en_o(mpr_en), .arr_rd_o(arr_rd), .arr_wr_o(arr_wr),
        .arr_act_o(arr_act));
    mpa_assertions mpa_assertions_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd(link.cmd),
        .ba(link.ba), .bg(link.bg), .mr_sel(link.mr_sel), .addr(link.addr),
        .dq_o(link.dq_o), .dq_oe(link.dq_oe), .alert(link.alert), .pl_i(pl));

    always #5 clk_i = ~clk_i;

    // Link monitor: read timing, burst capture, any access that reached the array
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (link.cmd === `MPA_CMD_RD) rd_cyc <= cyc;
        if (link.dq_oe === 1'b1) begin
            if (!oe_q) oe_cyc <= cyc;
            beats.push_back(link.dq_o);
        end
        oe_q <= (link.dq_oe === 1'b1);
        // Outputs are unknown until the first reset edge, so only count once out of reset
        if (rst_n_i === 1'b1 && (arr_rd | arr_wr | arr_act) !== 1'b0) arr_hits++;
    end

    // Beat n: lane k carries UI n of location loc+k, or of loc alone when serial
    function automatic logic [7:0] beat_exp(input logic [1:0] loc, input int n);
        logic [3:0] b;
        for (int k = 0; k < 4; k++) b[k] = stagger ? pat[2'(loc + k)][n] : pat[loc][n];
        return {b, b};
    endfunction

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic reg_wr(input logic [1:0] a, input logic [15:0] v);
        @(posedge clk_i);
        addr  <= a;
        wdata <= v;
        wr_s  <= 1'b1;
        @(posedge clk_i);
        wr_s  <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [1:0] a, output logic [15:0] v);
        @(posedge clk_i);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk_i);
        rd_s <= 1'b0;
        #1;
        v = rdata;
    endtask

    // Bounded wait for the sequence to finish, then let any burst drain
    task automatic wait_idle;
        int n;
        n = 0;
        #1;
        while (busy !== 1'b0 && n < 300) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (n >= 300) begin
            bad_count++;
            $display("unexpected busy stuck");
            close_out;
        end
        repeat (16) @(posedge clk_i);
    endtask

    // Kind nibble: go, write, refresh, exit
    task automatic go(input logic [3:0] kind, input logic [1:0] loc, input logic [7:0] v);
        reg_wr(2'h0, {kind, loc, v, 2'h0});
        wait_idle;
    endtask

    task automatic rd_check(input logic [1:0] loc);
        logic [15:0] r;
        beats.delete();
        go(4'h8, loc, 8'h00);
        `CHK("beat count", 8, beats.size())
        for (int n = 0; n < 8 && n < beats.size(); n++)
            `CHK("dq beat", beat_exp(loc, n), beats[n])
        // One edge loads the first beat and one more launches it past the delay
        `CHK("read delay", int'(`MPA_RL) + 2 + int'(pl), oe_cyc - rd_cyc)
        reg_rd(2'h2, r);
        `CHK("lane0 byte", pat[loc], r[7:0])
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        pat = '{`MPA_PAT0_RST, `MPA_PAT1_RST, `MPA_PAT2_RST, `MPA_PAT3_RST};
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        reg_rd(2'h1, d);
        `CHK("status", 2'h0, d[1:0])
        rd_check(2'h1);
        $display("test reset pattern done");
        foreach (rows[i]) begin
            @(posedge clk_i);
            stagger <= rows[i].stg;
            go(4'hC, rows[i].loc, rows[i].data);
            `CHK("mode", 1'b1, mpr_en)
            pat[rows[i].loc] = rows[i].data;
            rd_check(rows[i].loc);
            $display("test row %0d done", i);
        end
        @(posedge clk_i);
        pl <= 4'h3;
        rd_check(2'h2);
        @(posedge clk_i);
        pl <= 4'h0;
        $display("test parity latency done");
        // Second order arrives while busy and must be dropped
        reg_wr(2'h0, {4'hC, 2'h2, 8'h81, 2'h0});
        reg_wr(2'h0, {4'hC, 2'h3, 8'h7E, 2'h0});
        wait_idle;
        pat[2] = 8'h81;
        rd_check(2'h3);
        rd_check(2'h2);
        $display("test busy refusal done");
        go(4'hA, 2'h0, 8'h00);
        rd_check(2'h0);
        $display("test refresh done");
        go(4'h9, 2'h0, 8'h00);
        reg_rd(2'h1, d);
        `CHK("status after exit", 2'h0, d[1:0])
        `CHK("mode after exit", 1'b0, mpr_en)
        rd_check(2'h1);
        `CHK("array accesses", 0, arr_hits)
        $display("test exit done");
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        pat = '{`MPA_PAT0_RST, `MPA_PAT1_RST, `MPA_PAT2_RST, `MPA_PAT3_RST};
        rd_check(2'h0);
        $display("test second reset done");
        close_out;
    end
endmodule
